// file: verilog/bdf_top.sv
// Purpose: Bidirectional two-queue buffer with mailboxes, flags and parity.
// Assumes: Port clocks run well below half the system clock and are sampled.
// Notes: Data pins are split into input, output and output enable.
`timescale 1ns/1ps
module bdf_top (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [1:0] flag_select_i,
  input wire logic odd_even_i,
  input wire logic port_a_clock_i,
  input wire logic port_a_chip_select_n_i,
  input wire logic port_a_enable_i,
  input wire logic port_a_write_i,
  input wire logic port_a_mailbox_select_i,
  input wire logic port_a_parity_gen_i,
  input wire logic [bdf_pkg::DATA_W-1:0] port_a_data_bus_i,
  output logic [bdf_pkg::DATA_W-1:0] port_a_data_bus_o,
  output logic port_a_data_bus_oe_o,
  output logic port_a_empty_flag_n_o,
  output logic port_a_full_flag_n_o,
  output logic port_a_almost_empty_n_o,
  output logic port_a_almost_full_n_o,
  output logic port_a_parity_error_n_o,
  input wire logic port_b_clock_i,
  input wire logic port_b_chip_select_n_i,
  input wire logic port_b_enable_i,
  input wire logic port_b_write_i,
  input wire logic port_b_mailbox_select_i,
  input wire logic port_b_parity_gen_i,
  input wire logic [bdf_pkg::DATA_W-1:0] port_b_data_bus_i,
  output logic [bdf_pkg::DATA_W-1:0] port_b_data_bus_o,
  output logic port_b_data_bus_oe_o,
  output logic port_b_empty_flag_n_o,
  output logic port_b_full_flag_n_o,
  output logic port_b_almost_empty_n_o,
  output logic port_b_almost_full_n_o,
  output logic port_b_parity_error_n_o,
  output logic a_to_b_mailbox_flag_n_o,
  output logic b_to_a_mailbox_flag_n_o
);
  import bdf_pkg::*;

  logic [PIN_W-1:0] a_s;
  logic [PIN_W-1:0] b_s;
  logic [CFG_W-1:0] cfg_s;
  logic a_clk_prev_reg;
  logic b_clk_prev_reg;
  logic a_edge, b_edge;
  logic a_qual, b_qual;
  logic a_q_wr, a_q_rd, b_q_wr, b_q_rd;
  logic a_mb_wr, a_mb_rd, b_mb_wr, b_mb_rd;
  logic [DATA_W-1:0] ab_head, ba_head;
  logic [CNT_W-1:0] ab_count, ba_count;
  logic [CNT_W-1:0] offset_reg;
  logic [1:0] latch_cnt_reg;
  logic [3:0] a_raw, b_raw;
  logic [3:0] a_s1_reg, a_s2_reg, b_s1_reg, b_s2_reg;
  logic [DATA_W-1:0] mail_ab_reg, mail_ba_reg;
  logic mbf_ab_n_reg, mbf_ba_n_reg;
  logic [DATA_W-1:0] a_out_reg, b_out_reg;
  logic [DATA_W-1:0] a_src, b_src, a_gen, b_gen;
  logic [NUM_BYTES-1:0] a_perr, b_perr;
  logic a_perr_n_reg, b_perr_n_reg;

  // Port pins and port clocks come from other domains: two flops first
  bdf_sync #(.W(PIN_W), .RST_VAL(PIN_RESET)) u_sync_a (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .async_i({port_a_clock_i, port_a_chip_select_n_i, port_a_enable_i, port_a_write_i,
              port_a_mailbox_select_i, port_a_data_bus_i}),
    .sync_o(a_s)
  );

  bdf_sync #(.W(PIN_W), .RST_VAL(PIN_RESET)) u_sync_b (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .async_i({port_b_clock_i, port_b_chip_select_n_i, port_b_enable_i, port_b_write_i,
              port_b_mailbox_select_i, port_b_data_bus_i}),
    .sync_o(b_s)
  );

  bdf_sync #(.W(CFG_W), .RST_VAL(CFG_RESET)) u_sync_cfg (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .async_i({flag_select_i, odd_even_i, port_a_parity_gen_i, port_b_parity_gen_i}),
    .sync_o(cfg_s)
  );

  // Edge detection relies on a free-running port clock
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      a_clk_prev_reg <= 1'b1;
      b_clk_prev_reg <= 1'b1;
    end else begin
      a_clk_prev_reg <= a_s[PIN_CLK];
      b_clk_prev_reg <= b_s[PIN_CLK];
    end
  end

  assign a_edge = a_s[PIN_CLK] & ~a_clk_prev_reg;
  assign b_edge = b_s[PIN_CLK] & ~b_clk_prev_reg;
  assign a_qual = a_edge & ~a_s[PIN_CSN] & a_s[PIN_EN];
  assign b_qual = b_edge & ~b_s[PIN_CSN] & b_s[PIN_EN];

  // Direction and mailbox select split each qualified edge
  assign a_mb_wr = a_qual & a_s[PIN_WR] & a_s[PIN_MBX] & mbf_ab_n_reg;
  assign a_mb_rd = a_qual & ~a_s[PIN_WR] & a_s[PIN_MBX];
  assign a_q_wr = a_qual & a_s[PIN_WR] & ~a_s[PIN_MBX] & a_s2_reg[FLG_FULL];
  assign a_q_rd = a_qual & ~a_s[PIN_WR] & ~a_s[PIN_MBX] & a_s2_reg[FLG_EMPTY];
  assign b_mb_wr = b_qual & b_s[PIN_WR] & b_s[PIN_MBX] & mbf_ba_n_reg;
  assign b_mb_rd = b_qual & ~b_s[PIN_WR] & b_s[PIN_MBX];
  assign b_q_wr = b_qual & b_s[PIN_WR] & ~b_s[PIN_MBX] & b_s2_reg[FLG_FULL];
  assign b_q_rd = b_qual & ~b_s[PIN_WR] & ~b_s[PIN_MBX] & b_s2_reg[FLG_EMPTY];

  // Two independent queues, one per direction
  bdf_queue #(.DATA_W(DATA_W), .DEPTH(DEPTH)) u_q_ab (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .wr_en_i(a_q_wr),
    .wr_data_i(a_s[DATA_W-1:0]),
    .rd_en_i(b_q_rd),
    .head_o(ab_head),
    .count_o(ab_count)
  );

  bdf_queue #(.DATA_W(DATA_W), .DEPTH(DEPTH)) u_q_ba (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .wr_en_i(b_q_wr),
    .wr_data_i(b_s[DATA_W-1:0]),
    .rd_en_i(a_q_rd),
    .head_o(ba_head),
    .count_o(ba_count)
  );

  // Offset is caught once the synchronised select has settled after release
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      latch_cnt_reg <= '0;
      offset_reg <= OFFSET_PRESET0;
    end else if (latch_cnt_reg != LATCH_DELAY) begin
      latch_cnt_reg <= latch_cnt_reg + 1'b1;
      if (latch_cnt_reg == LATCH_DELAY - 2'h1) begin
        case (cfg_s[CFG_FS +: 2])
          2'h0: offset_reg <= OFFSET_PRESET0;
          2'h1: offset_reg <= OFFSET_PRESET1;
          2'h2: offset_reg <= OFFSET_PRESET2;
          default: offset_reg <= OFFSET_PRESET3;
        endcase
      end
    end
  end

  // Raw flag levels, active low
  always_comb begin
    a_raw[FLG_FULL] = ab_count != CNT_W'(DEPTH);
    a_raw[FLG_AFULL] = (CNT_W'(DEPTH) - ab_count) > offset_reg;
    a_raw[FLG_EMPTY] = ba_count != '0;
    a_raw[FLG_AEMPTY] = ba_count > offset_reg;
    b_raw[FLG_FULL] = ba_count != CNT_W'(DEPTH);
    b_raw[FLG_AFULL] = (CNT_W'(DEPTH) - ba_count) > offset_reg;
    b_raw[FLG_EMPTY] = ab_count != '0;
    b_raw[FLG_AEMPTY] = ab_count > offset_reg;
  end

  // Two stages stepped by the owning port clock; port A owns A-to-B writes
  // and B-to-A reads, so each flag lives on the clock of the port using it
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      a_s1_reg <= FLAG_RESET;
      a_s2_reg <= FLAG_RESET;
    end else if (a_edge) begin
      a_s1_reg <= a_raw;
      a_s2_reg <= a_s1_reg;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      b_s1_reg <= FLAG_RESET;
      b_s2_reg <= FLAG_RESET;
    end else if (b_edge) begin
      b_s1_reg <= b_raw;
      b_s2_reg <= b_s1_reg;
    end
  end

  assign port_a_full_flag_n_o = a_s2_reg[FLG_FULL];
  assign port_a_almost_full_n_o = a_s2_reg[FLG_AFULL];
  assign port_a_empty_flag_n_o = a_s2_reg[FLG_EMPTY];
  assign port_a_almost_empty_n_o = a_s2_reg[FLG_AEMPTY];
  assign port_b_full_flag_n_o = b_s2_reg[FLG_FULL];
  assign port_b_almost_full_n_o = b_s2_reg[FLG_AFULL];
  assign port_b_empty_flag_n_o = b_s2_reg[FLG_EMPTY];
  assign port_b_almost_empty_n_o = b_s2_reg[FLG_AEMPTY];

  // Mailboxes; if a write and a far read meet in one cycle the set wins,
  // so fresh mail is never lost
  always_ff @(posedge clk_i) begin
    if (a_mb_wr) begin
      mail_ab_reg <= a_s[DATA_W-1:0];
    end
    if (b_mb_wr) begin
      mail_ba_reg <= b_s[DATA_W-1:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mbf_ab_n_reg <= MBX_FLAG_RESET;
    end else if (a_mb_wr) begin
      mbf_ab_n_reg <= 1'b0;
    end else if (b_mb_rd) begin
      mbf_ab_n_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mbf_ba_n_reg <= MBX_FLAG_RESET;
    end else if (b_mb_wr) begin
      mbf_ba_n_reg <= 1'b0;
    end else if (a_mb_rd) begin
      mbf_ba_n_reg <= 1'b1;
    end
  end

  assign a_to_b_mailbox_flag_n_o = mbf_ab_n_reg;
  assign b_to_a_mailbox_flag_n_o = mbf_ba_n_reg;

  // Parity check on incoming words and generation on outgoing ones
  assign a_src = a_s[PIN_MBX] ? mail_ba_reg : ba_head;
  assign b_src = b_s[PIN_MBX] ? mail_ab_reg : ab_head;

  for (genvar g = 0; g < NUM_BYTES; g++) begin : g_par
    assign a_perr[g] = (^a_s[g*BYTE_W +: BYTE_W]) ^ cfg_s[CFG_ODD];
    assign b_perr[g] = (^b_s[g*BYTE_W +: BYTE_W]) ^ cfg_s[CFG_ODD];
    assign a_gen[g*BYTE_W +: PAR_POS] = a_src[g*BYTE_W +: PAR_POS];
    assign b_gen[g*BYTE_W +: PAR_POS] = b_src[g*BYTE_W +: PAR_POS];
    assign a_gen[g*BYTE_W + PAR_POS] = cfg_s[CFG_PGA] ?
        ((^a_src[g*BYTE_W +: PAR_POS]) ^ cfg_s[CFG_ODD]) : a_src[g*BYTE_W + PAR_POS];
    assign b_gen[g*BYTE_W + PAR_POS] = cfg_s[CFG_PGB] ?
        ((^b_src[g*BYTE_W +: PAR_POS]) ^ cfg_s[CFG_ODD]) : b_src[g*BYTE_W + PAR_POS];
  end

  // Result only reported; nothing on the data path looks at it
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      a_perr_n_reg <= 1'b1;
      b_perr_n_reg <= 1'b1;
    end else begin
      if (a_qual & a_s[PIN_WR]) begin
        a_perr_n_reg <= ~|a_perr;
      end
      if (b_qual & b_s[PIN_WR]) begin
        b_perr_n_reg <= ~|b_perr;
      end
    end
  end

  assign port_a_parity_error_n_o = a_perr_n_reg;
  assign port_b_parity_error_n_o = b_perr_n_reg;

  // Read data registers
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      a_out_reg <= '0;
    end else if (a_q_rd | a_mb_rd) begin
      a_out_reg <= a_gen;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      b_out_reg <= '0;
    end else if (b_q_rd | b_mb_rd) begin
      b_out_reg <= b_gen;
    end
  end

  // Two-way buses, driven only while selected and set to read
  assign port_a_data_bus_o = a_out_reg;
  assign port_a_data_bus_oe_o = ~a_s[PIN_CSN] & ~a_s[PIN_WR];
  assign port_b_data_bus_o = b_out_reg;
  assign port_b_data_bus_oe_o = ~b_s[PIN_CSN] & ~b_s[PIN_WR];

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  sequence s_ab_write_only;
    a_q_wr && !b_q_rd && ab_count != CNT_W'(DEPTH);
  endsequence

  sequence s_mail_written;
    a_mb_wr ##1 !a_to_b_mailbox_flag_n_o;
  endsequence

  a_depth_bound: assert property (ab_count <= CNT_W'(DEPTH) && ba_count <= CNT_W'(DEPTH))
    else $error("queue count above depth");
  a_idle_stable: assert property (!a_qual && !b_qual |=> $stable(ab_count))
    else $error("queue moved without a qualified edge");
  a_write_grows: assert property (s_ab_write_only |=> ab_count == $past(ab_count) + 7'h01)
    else $error("write did not add one word");
  a_same_edge: assert property (a_q_wr && b_q_rd && ab_count != '0
      && ab_count != CNT_W'(DEPTH) |=> $stable(ab_count))
    else $error("simultaneous read and write disturbed count");
  a_hiz_on_cs: assert property (a_s[PIN_CSN] |-> !port_a_data_bus_oe_o)
    else $error("port A driven while deselected");
  a_full_blocks: assert property (a_qual && a_s[PIN_WR] && !a_s[PIN_MBX]
      && !port_a_full_flag_n_o && !b_q_rd |=> $stable(ab_count))
    else $error("write taken while full flag low");
  a_mail_flag: assert property (a_mb_wr |-> s_mail_written)
    else $error("mailbox flag did not fall on write");
  a_mail_release: assert property (b_mb_rd && !a_mb_wr |=> mbf_ab_n_reg)
    else $error("mailbox flag did not rise on read");
  a_empty_stage: assert property (b_edge && b_s1_reg[FLG_EMPTY]
      |=> port_b_empty_flag_n_o)
    else $error("empty flag missed second stage");
  a_ae_level: assert property (b_edge
      |=> b_s1_reg[FLG_AEMPTY] == ($past(ab_count) > $past(offset_reg)))
    else $error("almost empty level wrong");
  a_af_level: assert property (a_edge
      |=> a_s1_reg[FLG_AFULL]
      == ((CNT_W'(DEPTH) - $past(ab_count)) > $past(offset_reg)))
    else $error("almost full level wrong");
endmodule

// file: verilog/bdf_pkg.sv
// Purpose: Shared constants for the two-queue bidirectional buffer with mailboxes.
// Assumes: One system clock; both port clocks are sampled as ordinary inputs.
// Notes: Offset presets and parity bit placement are plain defaults.
//
// What this block does
// - Two 64-word by 36-bit queues, one per direction.
// - Transfers happen only on a qualified rising edge of the port clock.
// - Port clocks are independent; both may be unrelated or identical.
// - A read and a write on the same edge both complete cleanly unless the queue is full (write dropped) or empty (read refused).
// - Full and almost-full pass two stages on the writing port clock.
// - Empty and almost-empty pass two stages on the reading port clock.
// - Port A flags update on port A clock rising edges.
// - Port A almost-empty low when B-to-A count is at most the offset.
// - Port B almost-empty low when A-to-B count is at most the offset.
// - Port A almost-full low when A-to-B free space is at most the offset.
// - Port B almost-full low when B-to-A free space is at most the offset.
// - Port A transfers only while its chip select is low.
// - Port A data pins float while its chip select is high.
// - Each port has a 36-bit two-way data bus.
// - Two 36-bit mailbox registers bypass the queues, one per direction.
// - Each mailbox has a flag showing unread new mail.
// - Parity is checked passively and never alters a transfer.
// - Each port may generate parity on words it reads out.
// - Port A transfers only while its enable is high.
// - Empty flag low at reset, blocks reads, rises second edge after data.
// - Full flag low at reset, blocks writes, rises second edge after reset.
// - Mailbox flag low on write, blocks writes, high on far read and reset.
package bdf_pkg;
  localparam int DATA_W = 36;
  localparam int DEPTH = 64;
  localparam int CNT_W = 7;
  localparam int BYTE_W = 9;
  localparam int NUM_BYTES = 4;
  localparam int PAR_POS = 8;
  localparam int SYNC_W = 2;
  // Synchronised port bundle layout
  localparam int PIN_W = 41;
  localparam int PIN_CLK = 40;
  localparam int PIN_CSN = 39;
  localparam int PIN_EN = 38;
  localparam int PIN_WR = 37;
  localparam int PIN_MBX = 36;
  // Clock bit resets high so a port clock already high at release is no false edge
  localparam logic [PIN_W-1:0] PIN_RESET = 41'h180_0000_0000;
  // Synchronised configuration layout
  localparam int CFG_W = 5;
  localparam int CFG_FS = 3;
  localparam int CFG_ODD = 2;
  localparam int CFG_PGA = 1;
  localparam int CFG_PGB = 0;
  localparam logic [CFG_W-1:0] CFG_RESET = 5'h00;
  // Flag vector positions, all active low
  localparam int FLG_FULL = 0;
  localparam int FLG_AFULL = 1;
  localparam int FLG_EMPTY = 2;
  localparam int FLG_AEMPTY = 3;
  localparam logic [3:0] FLAG_RESET = 4'h0;
  localparam logic MBX_FLAG_RESET = 1'b1;
  // Select pins need two synchroniser edges before the latch may read them
  localparam logic [1:0] LATCH_DELAY = 2'h3;
  // Almost-full and almost-empty offset presets, chosen by the flag select pins
  localparam logic [CNT_W-1:0] OFFSET_PRESET0 = 7'h10;
  localparam logic [CNT_W-1:0] OFFSET_PRESET1 = 7'h0C;
  localparam logic [CNT_W-1:0] OFFSET_PRESET2 = 7'h08;
  localparam logic [CNT_W-1:0] OFFSET_PRESET3 = 7'h04;
endpackage

// file: verilog/bdf_sync.sv
// Purpose: Two-flop synchroniser for a group of asynchronous inputs.
// Assumes: Group members are sampled together on the system clock.
// Notes: Only the second stage is visible outside.
`timescale 1ns/1ps
module bdf_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  import bdf_pkg::*;

  logic [W-1:0] meta_reg;

  if (W < 1) begin : g_chk
    $error("bdf_sync width must be at least one");
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_reg <= RST_VAL;
      sync_o <= RST_VAL;
    end else begin
      meta_reg <= async_i;
      sync_o <= meta_reg;
    end
  end
endmodule

// file: verilog/bdf_queue.sv
// Purpose: One direction of storage, a circular buffer with its own word count.
// Assumes: Write and read strobes are single-cycle pulses on the system clock.
// Notes: Guards itself against overflow, since the port flags lag the count.
`timescale 1ns/1ps
module bdf_queue #(
  parameter int DATA_W = bdf_pkg::DATA_W,
  parameter int DEPTH = bdf_pkg::DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic wr_en_i,
  input wire logic [DATA_W-1:0] wr_data_i,
  input wire logic rd_en_i,
  output logic [DATA_W-1:0] head_o,
  output logic [$clog2(DEPTH):0] count_o
);
  import bdf_pkg::*;

  localparam int PW = $clog2(DEPTH);

  if ((1 << PW) != DEPTH || DEPTH < 2) begin : g_chk
    $error("bdf_queue depth must be a power of two");
  end

  logic [DATA_W-1:0] mem [DEPTH];
  logic [PW:0] wr_ptr_reg;
  logic [PW:0] rd_ptr_reg;
  logic wr_ok;
  logic rd_ok;

  assign count_o = wr_ptr_reg - rd_ptr_reg;
  assign wr_ok = wr_en_i && (count_o != (PW+1)'(DEPTH));
  assign rd_ok = rd_en_i && (count_o != '0);
  assign head_o = mem[rd_ptr_reg[PW-1:0]];

  // Separate pointers let a read and a write land on the same edge
  always_ff @(posedge clk_i) begin
    if (wr_ok) begin
      mem[wr_ptr_reg[PW-1:0]] <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr_reg <= '0;
    end else if (wr_ok) begin
      wr_ptr_reg <= wr_ptr_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_ptr_reg <= '0;
    end else if (rd_ok) begin
      rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end
endmodule

// file: testbench/bdf_port_agent.sv
// Purpose: Processor model that stands on one port of the buffer.
// Assumes: Port clock half period HALF ns, well above three system clocks.
// Notes: Idle data lines show the inverse of the last word driven.
`timescale 1ns/1ps
module bdf_port_agent #(
  parameter int HALF = 250,
  parameter int PHASE = 13
) (
  input wire logic [bdf_pkg::DATA_W-1:0] bus_i,
  output logic clock_o,
  output logic chip_select_n_o,
  output logic enable_o,
  output logic write_o,
  output logic mailbox_select_o,
  output logic [bdf_pkg::DATA_W-1:0] data_o
);
  import bdf_pkg::*;
  initial begin
    clock_o = 1'b0;
    #PHASE;
    forever #HALF clock_o = ~clock_o;
  end
  initial begin
    chip_select_n_o = 1'b1;
    enable_o = 1'b0;
    write_o = 1'b0;
    mailbox_select_o = 1'b0;
    data_o = '0;
  end
  // Read data is taken one port edge later, with enable already dropped
  task automatic xfer(input logic csn, input logic en, input logic wr, input logic mbx,
                      input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rd);
    @(negedge clock_o);
    chip_select_n_o = csn;
    enable_o = en;
    write_o = wr;
    mailbox_select_o = mbx;
    data_o = wd;
    @(posedge clock_o);
    @(negedge clock_o);
    enable_o = 1'b0;
    data_o = ~wd;
    @(posedge clock_o);
    rd = bus_i;
    #1;
    chip_select_n_o = 1'b1;
  endtask
endmodule

// file: testbench/bdf_top_bench.sv
// Purpose: Self-checking bench for the two-queue buffer with mailboxes.
// Assumes: Offset preset 3, four words, then preset 0, sixteen words; port clocks near 2 MHz.
// Notes: All port traffic goes through the two port models.
`timescale 1ns/1ps
module bdf_top_bench;
  import bdf_pkg::*;
  logic clk_i;
  logic rst_b_i;
  logic odd_even, pga, pgb;
  logic [1:0] fsel;
  logic a_clk, a_csn, a_en, a_wr, a_mbx, a_oe, a_ef, a_ff, a_ae, a_af, a_pe, mb1;
  logic b_clk, b_csn, b_en, b_wr, b_mbx, b_oe, b_ef, b_ff, b_ae, b_af, b_pe, mb2;
  logic [DATA_W-1:0] a_do, a_di, b_do, b_di, a_bus, b_bus, ra, rb, w;
  int fails = 0;
  int total_checks = 0;
  int nw = 0;
  // Wire level: the device wins only while it drives
  assign a_bus = a_oe ? a_do : a_di;
  assign b_bus = b_oe ? b_do : b_di;
  bdf_top DUT (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .flag_select_i(fsel),
    .odd_even_i(odd_even),
    .port_a_clock_i(a_clk),
    .port_a_chip_select_n_i(a_csn),
    .port_a_enable_i(a_en),
    .port_a_write_i(a_wr),
    .port_a_mailbox_select_i(a_mbx),
    .port_a_parity_gen_i(pga),
    .port_a_data_bus_i(a_bus),
    .port_a_data_bus_o(a_do),
    .port_a_data_bus_oe_o(a_oe),
    .port_a_empty_flag_n_o(a_ef),
    .port_a_full_flag_n_o(a_ff),
    .port_a_almost_empty_n_o(a_ae),
    .port_a_almost_full_n_o(a_af),
    .port_a_parity_error_n_o(a_pe),
    .port_b_clock_i(b_clk),
    .port_b_chip_select_n_i(b_csn),
    .port_b_enable_i(b_en),
    .port_b_write_i(b_wr),
    .port_b_mailbox_select_i(b_mbx),
    .port_b_parity_gen_i(pgb),
    .port_b_data_bus_i(b_bus),
    .port_b_data_bus_o(b_do),
    .port_b_data_bus_oe_o(b_oe),
    .port_b_empty_flag_n_o(b_ef),
    .port_b_full_flag_n_o(b_ff),
    .port_b_almost_empty_n_o(b_ae),
    .port_b_almost_full_n_o(b_af),
    .port_b_parity_error_n_o(b_pe),
    .a_to_b_mailbox_flag_n_o(mb1),
    .b_to_a_mailbox_flag_n_o(mb2)
  );
  bdf_port_agent #(.HALF(250), .PHASE(13)) PA (
    .bus_i(a_bus),
    .clock_o(a_clk),
    .chip_select_n_o(a_csn),
    .enable_o(a_en),
    .write_o(a_wr),
    .mailbox_select_o(a_mbx),
    .data_o(a_di)
  );
  bdf_port_agent #(.HALF(275), .PHASE(101)) PB (
    .bus_i(b_bus),
    .clock_o(b_clk),
    .chip_select_n_o(b_csn),
    .enable_o(b_en),
    .write_o(b_wr),
    .mailbox_select_o(b_mbx),
    .data_o(b_di)
  );
  task automatic chk(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic cf(input logic g, input logic e);
    chk({35'h0, g}, {35'h0, e});
  endtask
  function automatic logic [DATA_W-1:0] pgen(input logic [DATA_W-1:0] d, input logic odd);
    for (int i = 0; i < NUM_BYTES; i++) begin
      d[i*BYTE_W+PAR_POS] = (^d[i*BYTE_W +: PAR_POS]) ^ odd;
    end
    return d;
  endfunction
  task automatic wa(input int n);
    repeat (n) @(posedge a_clk);
    #1;
  endtask
  task automatic final_report;
    $display("Checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // Bounds the whole run in case a port hangs
  initial begin
    #1000000;
    fails++;
    final_report();
  end
  initial begin
    rst_b_i = 1'b0;
    fsel = 2'h3;
    odd_even = 1'b1;
    pga = 1'b0;
    pgb = 1'b0;
    repeat (12) @(negedge clk_i);
    cf(a_ff, 1'b0);
    cf(a_ef, 1'b0);
    cf(mb1, 1'b1);
    cf(a_oe, 1'b0);
    rst_b_i = 1'b1;
    wa(5);
    cf(a_ff, 1'b1);
    cf(b_ff, 1'b1);
    cf(b_ae, 1'b0);
    PA.xfer(1'b1, 1'b1, 1'b1, 1'b0, 36'hBAD, ra);
    PA.xfer(1'b0, 1'b0, 1'b1, 1'b0, 36'hBAD, ra);
    PA.xfer(1'b1, 1'b1, 1'b0, 1'b0, 36'h5, ra);
    chk(ra, ~36'h5);
    for (int n = 1; n <= DEPTH; n++) begin
      PA.xfer(1'b0, 1'b1, 1'b1, 1'b0, {28'hC000000, 8'(n)}, ra);
      if (n == 4 || n == 5) begin
        wa(4);
        cf(b_ae, n == 5);
        cf(b_ef, 1'b1);
      end
      if (n == 59 || n == 60) begin
        wa(4);
        cf(a_af, n == 59);
      end
    end
    for (int i = 0; i < 6 && a_ff !== 1'b0; i++) wa(1);
    cf(a_ff, 1'b0);
    if (a_ff !== 1'b0) final_report();
    PA.xfer(1'b0, 1'b1, 1'b1, 1'b0, 36'hDEAD, ra);
    for (int n = 1; n <= DEPTH; n++) begin
      PB.xfer(1'b0, 1'b1, 1'b0, 1'b0, 36'h0, rb);
      chk(rb, {28'hC000000, 8'(n)});
    end
    for (int i = 0; i < 6 && b_ef !== 1'b0; i++) wa(1);
    cf(b_ef, 1'b0);
    if (b_ef !== 1'b0) final_report();
    PB.xfer(1'b0, 1'b1, 1'b0, 1'b0, 36'h0, rb);
    chk(rb, {28'hC000000, 8'h40});
    @(negedge clk_i);
    pgb = 1'b1;
    odd_even = 1'b0;
    // Writer and reader overlap on the same queue
    fork
      for (int n = 0; n < 20; n++) begin
        PA.xfer(1'b0, 1'b1, 1'b1, 1'b0, {28'h7000000, 8'(n)}, ra);
        nw++;
      end
      begin
        for (int i = 0; i < 40 && nw < 8; i++) wa(1);
        if (nw < 8) begin
          fails++;
          final_report();
        end
        for (int n = 0; n < 20; n++) begin
          PB.xfer(1'b0, 1'b1, 1'b0, 1'b0, 36'h0, rb);
          chk(rb, pgen({28'h7000000, 8'(n)}, 1'b0));
        end
      end
    join
    for (int k = 0; k < 2; k++) begin
      @(negedge clk_i);
      odd_even = k[0];
      pga = k[0];
      w = pgen(36'h1_2345_6789 + 36'(k), k[0]);
      PB.xfer(1'b0, 1'b1, 1'b1, 1'b0, w ^ 36'h1, rb);
      cf(b_pe, 1'b0);
      PB.xfer(1'b0, 1'b1, 1'b1, 1'b0, w, rb);
      cf(b_pe, 1'b1);
      wa(4);
      cf(a_ae, 1'b0);
      cf(b_af, 1'b1);
      PA.xfer(1'b0, 1'b1, 1'b0, 1'b0, 36'h0, ra);
      chk(ra, k[0] ? pgen(w ^ 36'h1, 1'b1) : w ^ 36'h1);
      PA.xfer(1'b0, 1'b1, 1'b0, 1'b0, 36'h0, ra);
      chk(ra, w);
    end
    @(negedge clk_i);
    pga = 1'b0;
    pgb = 1'b0;
    PA.xfer(1'b0, 1'b1, 1'b1, 1'b1, 36'h3_1111_0000, ra);
    cf(mb1, 1'b0);
    cf(a_pe, 1'b0);
    PA.xfer(1'b0, 1'b1, 1'b1, 1'b1, 36'h3_2222_0000, ra);
    PB.xfer(1'b0, 1'b1, 1'b0, 1'b1, 36'h0, rb);
    chk(rb, 36'h3_1111_0000);
    cf(mb1, 1'b1);
    PB.xfer(1'b0, 1'b1, 1'b1, 1'b1, 36'h4_4444_0000, rb);
    cf(mb2, 1'b0);
    PA.xfer(1'b0, 1'b1, 1'b0, 1'b1, 36'h0, ra);
    chk(ra, 36'h4_4444_0000);
    cf(mb2, 1'b1);
    // Second reset in mid-run with the widest offset preset
    @(negedge clk_i);
    fsel = 2'h0;
    rst_b_i = 1'b0;
    repeat (3) @(negedge clk_i);
    cf(a_ff, 1'b0);
    cf(b_ef, 1'b0);
    rst_b_i = 1'b1;
    wa(5);
    cf(a_ff, 1'b1);
    for (int n = 1; n <= 17; n++) begin
      PA.xfer(1'b0, 1'b1, 1'b1, 1'b0, 36'(n), ra);
      if (n >= 16) begin
        wa(4);
        cf(b_ae, n == 17);
        cf(a_af, 1'b1);
      end
    end
    final_report();
  end
endmodule
